// ===== shared/ser_pkg.sv
// Constants for the status event reporting block.
// Assumes a command interpreter that issues single-cycle register strobes.
`default_nettype none
package ser_pkg;

  // Register widths and group count
  localparam int REG_W = 16;
  localparam int SEL_W = 4;
  localparam int STB_W = 8;
  localparam int NUM_GRP = 2;

  // Group index, held in the top selector bit
  localparam int SEL_GRP_BIT = 3;
  localparam logic [0:0] GRP_OPER = 1'h0;
  localparam logic [0:0] GRP_DATA = 1'h1;

  // Register codes, low three selector bits
  localparam logic [2:0] REG_COND = 3'h0;
  localparam logic [2:0] REG_EVENT = 3'h1;
  localparam logic [2:0] REG_ENABLE = 3'h2;
  localparam logic [2:0] REG_RISE = 3'h3;
  localparam logic [2:0] REG_FALL = 3'h4;

  // Status byte positions of the group summaries
  localparam int STB_DATA_BIT = 3;
  localparam int STB_OPER_BIT = 7;

  // Power-on and preset values
  localparam logic [15:0] COND_RST = 16'h0000;
  localparam logic [15:0] EVENT_RST = 16'h0000;
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [15:0] RISE_RST = 16'hffff;
  localparam logic [15:0] FALL_RST = 16'h0000;
  localparam logic [15:0] RDATA_RST = 16'h0000;
  localparam logic [7:0] STB_RST = 8'h00;

endpackage
`default_nettype wire

// ===== shared/ser_grp_if.sv
// Carrier between the top and one status group.
// Assumes one clock; all fields are same-cycle strobes or registered values.
`timescale 1ns/1ns
`default_nettype none
interface ser_grp_if;
  logic [15:0] cond_in;
  logic [15:0] wdata;
  logic wr_enable;
  logic wr_rise;
  logic wr_fall;
  logic rd_event;
  logic clear_status;
  logic preset;
  logic [15:0] cond;
  logic [15:0] event_flags;
  logic [15:0] enable;
  logic [15:0] rise_filter;
  logic [15:0] falling_filter;
  logic summary;

  modport ctl (
    output cond_in, wdata, wr_enable, wr_rise, wr_fall, rd_event, clear_status, preset,
    input cond, event_flags, enable, rise_filter, falling_filter, summary
  );
  modport grp (
    input cond_in, wdata, wr_enable, wr_rise, wr_fall, rd_event, clear_status, preset,
    output cond, event_flags, enable, rise_filter, falling_filter, summary
  );
endinterface
`default_nettype wire

// ===== design/ser_group.sv
// One status group: live condition, transition filters, sticky events, mask.
// Assumes strobes from the top are single-cycle and already qualified.
`timescale 1ns/1ns
`default_nettype none
module ser_group (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Link to the top
  ser_grp_if.grp gi
);

  logic [15:0] cond_q;
  logic [15:0] event_q;
  logic [15:0] event_d;
  logic [15:0] enable_q;
  logic [15:0] rise_q;
  logic [15:0] fall_q;
  logic [15:0] rise_hit;
  logic [15:0] fall_hit;
  logic [15:0] event_clr;

  // Bitwise, so each event only sees its own condition bit
  assign rise_hit = gi.cond_in & ~cond_q & rise_q;
  assign fall_hit = ~gi.cond_in & cond_q & fall_q;
  assign event_clr = (gi.rd_event || gi.clear_status) ? 16'hffff : 16'h0000;
  // Set beats clear so a coincident edge survives the read
  assign event_d = (event_q & ~event_clr) | rise_hit | fall_hit;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cond_q <= ser_pkg::COND_RST;
      event_q <= ser_pkg::EVENT_RST;
    end else if (ce) begin
      cond_q <= gi.cond_in;
      event_q <= event_d;
    end
  end

  // Only preset and writes touch these; no restore or recall input exists
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= ser_pkg::ENABLE_RST;
      rise_q <= ser_pkg::RISE_RST;
      fall_q <= ser_pkg::FALL_RST;
    end else if (ce) begin
      if (gi.preset) begin
        enable_q <= ser_pkg::ENABLE_RST;
        rise_q <= ser_pkg::RISE_RST;
        fall_q <= ser_pkg::FALL_RST;
      end else begin
        if (gi.wr_enable) enable_q <= gi.wdata;
        if (gi.wr_rise) rise_q <= gi.wdata;
        if (gi.wr_fall) fall_q <= gi.wdata;
      end
    end
  end

  assign gi.cond = cond_q;
  assign gi.event_flags = event_q;
  assign gi.enable = enable_q;
  assign gi.rise_filter = rise_q;
  assign gi.falling_filter = fall_q;
  assign gi.summary = |(event_q & enable_q);

endmodule
`default_nettype wire

// ===== design/ser_top.sv
// Status event reporting: operation and data-quality groups, command port.
// Assumes condition inputs and commands come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - A set falling-filter bit lets a true-to-false condition change set its event bit.
// - A set rising-filter bit lets a false-to-true condition change set its event bit.
// - Each event bit is driven only by the condition bit in the same position.
// - A set event bit stays set until an event read, clear-status or power-on.
// - The data-quality events clear on clear-status, on their own read, and at power-on.
// - Reading the condition register clears nothing, and it is zero after power-on.
// - All group registers are 16 bits; bits above read zero and are ignored on write.
// - A mask or filter write loads the integer value's binary bits.
// - A read returns the register bits as an unsigned binary-weighted integer.
// - The OR of enabled data-quality events drives status byte bit 3.
// - The OR of enabled operation events drives status byte bit 7.
// - Preset clears all masks and falling filters and sets all rising filters.
// - At power-on the falling filters are all zero.
// - At power-on the rising filters are all ones.
// - At power-on the enable masks are zero.
// - Masks and filters survive defaults-restore and save or recall.
module ser_top (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Live conditions
  input wire logic [15:0] oper_cond_in,
  input wire logic [15:0] data_cond_in,
  // Register command port
  input wire logic [3:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_err,
  // Group commands
  input wire logic clear_status_command,
  input wire logic preset_command,
  // Summary
  output logic [7:0] status_byte,
  output logic oper_summary,
  output logic data_summary
);

  ser_grp_if gi [ser_pkg::NUM_GRP] ();

  logic [2:0] reg_code;
  logic grp_sel;
  logic code_valid;
  logic code_writable;
  logic wr_ok;
  logic rd_ok;
  logic bad_access;
  logic [1:0][15:0] cond_in_a;
  logic [1:0][15:0] rd_word;
  logic [1:0] grp_hit;
  logic [1:0] summary_a;
  logic [15:0] rd_sel_word;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic err_q;
  logic [7:0] stb_d;
  logic [7:0] stb_q;

  // Selector decode
  assign reg_code = reg_sel[2:0];
  assign grp_sel = reg_sel[ser_pkg::SEL_GRP_BIT];
  assign code_valid = (reg_code == ser_pkg::REG_COND) ||
                      (reg_code == ser_pkg::REG_EVENT) ||
                      (reg_code == ser_pkg::REG_ENABLE) ||
                      (reg_code == ser_pkg::REG_RISE) ||
                      (reg_code == ser_pkg::REG_FALL);
  // Condition and event are read-only; writing them is refused
  assign code_writable = (reg_code == ser_pkg::REG_ENABLE) ||
                         (reg_code == ser_pkg::REG_RISE) ||
                         (reg_code == ser_pkg::REG_FALL);
  // A write and read together is ambiguous, so both are refused
  assign wr_ok = reg_wr && !reg_rd && code_writable;
  assign rd_ok = reg_rd && !reg_wr && code_valid;
  assign bad_access = (reg_wr || reg_rd) && !wr_ok && !rd_ok;

  assign cond_in_a[0] = oper_cond_in;
  assign cond_in_a[1] = data_cond_in;

  genvar g;
  generate
    for (g = 0; g < ser_pkg::NUM_GRP; g++) begin : grp
      assign grp_hit[g] = (grp_sel == 1'(g));
      assign gi[g].cond_in = cond_in_a[g];
      // Upper data bits are dropped here
      assign gi[g].wdata = reg_wdata[15:0];
      assign gi[g].wr_enable = wr_ok && grp_hit[g] && (reg_code == ser_pkg::REG_ENABLE);
      assign gi[g].wr_rise = wr_ok && grp_hit[g] && (reg_code == ser_pkg::REG_RISE);
      assign gi[g].wr_fall = wr_ok && grp_hit[g] && (reg_code == ser_pkg::REG_FALL);
      // Event read clears the group's events
      assign gi[g].rd_event = rd_ok && grp_hit[g] && (reg_code == ser_pkg::REG_EVENT);
      assign gi[g].clear_status = clear_status_command;
      assign gi[g].preset = preset_command;
      assign summary_a[g] = gi[g].summary;
      assign rd_word[g] = (reg_code == ser_pkg::REG_COND) ? gi[g].cond :
                          (reg_code == ser_pkg::REG_EVENT) ? gi[g].event_flags :
                          (reg_code == ser_pkg::REG_ENABLE) ? gi[g].enable :
                          (reg_code == ser_pkg::REG_RISE) ? gi[g].rise_filter :
                          (reg_code == ser_pkg::REG_FALL) ? gi[g].falling_filter :
                          16'h0000;

      ser_group u_group (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .gi(gi[g])
      );
    end
  endgenerate

  assign rd_sel_word = grp_sel ? rd_word[1] : rd_word[0];

  // Event read returns the pre-clear value, captured this edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= ser_pkg::RDATA_RST;
      rvalid_q <= 1'h0;
      err_q <= 1'h0;
    end else if (ce) begin
      if (rd_ok) rdata_q <= rd_sel_word;
      rvalid_q <= rd_ok;
      err_q <= bad_access;
    end
  end

  // Status byte, only bits 3 and 7 belong to this block
  always_comb begin
    stb_d = ser_pkg::STB_RST;
    stb_d[ser_pkg::STB_DATA_BIT] = summary_a[1];
    stb_d[ser_pkg::STB_OPER_BIT] = summary_a[0];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stb_q <= ser_pkg::STB_RST;
    end else if (ce) begin
      stb_q <= stb_d;
    end
  end

  // Unsigned zero-extended word; bits above 15 read zero
  assign reg_rdata = {16'h0000, rdata_q};
  assign reg_rvalid = rvalid_q;
  assign reg_err = err_q;
  assign status_byte = stb_q;
  assign oper_summary = stb_q[ser_pkg::STB_OPER_BIT];
  assign data_summary = stb_q[ser_pkg::STB_DATA_BIT];

endmodule
`default_nettype wire

// ===== tb/ser_top_sva.sv
// Port-level assertions for the status event reporting top.
// Assumes one clock domain; attached to every ser_top by the bind below.
`timescale 1ns/1ns
`default_nettype none
module ser_top_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Command side
  input wire logic [3:0] reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic preset_command,
  // Answers
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_err,
  input wire logic [7:0] status_byte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr_en;
    ce && reg_wr && !reg_rd && reg_sel[2:0] == 3'h2;
  endsequence
  sequence s_rd_same;
    ce && reg_rd && !reg_wr && $stable(reg_sel);
  endsequence
  chk_read_answer: assert property (
    ce && reg_rd && !reg_wr && reg_sel[2:0] <= 3'h4 |=> reg_rvalid && !reg_err) else $error("read unanswered");
  chk_bad_write_err: assert property (
    ce && reg_wr && (reg_sel[2:0] <= 3'h1 || reg_sel[2:0] >= 3'h5) |=> reg_err && !reg_rvalid)
    else $error("bad write accepted");
  chk_both_strobes: assert property (ce && reg_wr && reg_rd |=> reg_err) else $error("dual strobe taken");
  // A frozen clock keeps the old answer, so only enabled idle cycles count
  chk_idle_quiet: assert property (
    ce && !(reg_wr || reg_rd) |=> !reg_rvalid && !reg_err) else $error("answer without strobe");
  chk_rdata_upper: assert property (reg_rdata[31:16] == 16'h0000) else $error("rdata upper bits set");
  chk_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("rdata moved");
  chk_enable_back: assert property (
    s_wr_en ##1 !reg_wr ##1 s_rd_same |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 3))
    else $error("enable readback wrong");
  chk_unused_bits: assert property ((status_byte & 8'h77) == 8'h00) else $error("status spare bit set");
  chk_preset_sum: assert property (
    ce && preset_command ##1 ce |=> status_byte == 8'h00) else $error("summary after preset");
endmodule
bind ser_top ser_top_sva u_sva (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .preset_command(preset_command), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .reg_err(reg_err), .status_byte(status_byte));
`default_nettype wire

// ===== tb/status_event_reporting_tb.sv
// Self-checking bench for the status event reporting top.
// Assumes the bound checker; inputs move at falling edges.
`timescale 1ns/1ns
`default_nettype none
module status_event_reporting_tb;
  localparam logic [0:0] D = ser_pkg::GRP_DATA, O = ser_pkg::GRP_OPER;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic clear_status_command = 1'b0, preset_command = 1'b0, reg_rvalid, reg_err, oper_summary, data_summary;
  logic [15:0] oper_cond_in = 16'h0000, data_cond_in = 16'h0000;
  logic [3:0] reg_sel = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic [7:0] status_byte;
  int bad_count = 0, compares = 0;
  always #5 clk = ~clk;
  ser_top dut (.clk(clk), .rst_b(rst_b), .ce(ce), .oper_cond_in(oper_cond_in), .data_cond_in(data_cond_in),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_err(reg_err), .clear_status_command(clear_status_command),
    .preset_command(preset_command), .status_byte(status_byte), .oper_summary(oper_summary),
    .data_summary(data_summary));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One strobe; its answer stands at the next falling edge
  task automatic op(input logic [3:0] sel, input logic w, input logic r, input logic [31:0] d);
    @(negedge clk);
    reg_sel = sel;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = r;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  task automatic rd(input logic [3:0] sel, input logic [15:0] exp);
    op(sel, 1'b0, 1'b1, 32'h0000_0000);
    chk(32'(reg_rvalid), 32'h1);
    chk(reg_rdata, {16'h0000, exp});
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // Power-on and preset leave the same pattern
  task automatic t_defaults();
    for (int g = 0; g < 2; g++) begin
      rd({g[0], ser_pkg::REG_ENABLE}, 16'h0000);
      rd({g[0], ser_pkg::REG_FALL}, 16'h0000);
      rd({g[0], ser_pkg::REG_RISE}, 16'hffff);
    end
  endtask
  task automatic t_power_on();
    t_defaults();
    rd({D, ser_pkg::REG_COND}, 16'h0000);
    rd({D, ser_pkg::REG_EVENT}, 16'h0000);
  endtask
  task automatic t_access();
    op({O, ser_pkg::REG_ENABLE}, 1'b1, 1'b0, 32'habcd_1234);
    rd({O, ser_pkg::REG_ENABLE}, 16'h1234);
    op({O, ser_pkg::REG_COND}, 1'b1, 1'b0, 32'h0000_00ff);
    chk(32'(reg_err), 32'h1);
    op(4'h5, 1'b1, 1'b0, 32'h0000_0000);
    chk(32'(reg_err), 32'h1);
    op({O, ser_pkg::REG_ENABLE}, 1'b1, 1'b1, 32'h0000_0000);
    chk(32'(reg_err), 32'h1);
    rd({O, ser_pkg::REG_COND}, 16'h0000);
  endtask
  // Edge in the cycle of an event read; also a write while frozen
  task automatic t_race();
    @(negedge clk);
    reg_sel = {D, ser_pkg::REG_EVENT};
    reg_rd = 1'b1;
    data_cond_in = 16'h0001;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, 32'h0000_0000);
    repeat (2) @(negedge clk);
    chk(32'(data_summary), 32'h1);
    rd({D, ser_pkg::REG_EVENT}, 16'h0001);
    data_cond_in = 16'h0000;
    ce = 1'b0;
    op({D, ser_pkg::REG_ENABLE}, 1'b1, 1'b0, 32'h0000_00ff);
    ce = 1'b1;
    rd({D, ser_pkg::REG_ENABLE}, 16'h0003);
    rd({D, ser_pkg::REG_EVENT}, 16'h0000);
  endtask
  // Bit 0 counts rises only, bit 1 counts falls only
  task automatic t_data();
    op({D, ser_pkg::REG_RISE}, 1'b1, 1'b0, 32'h0000_0001);
    op({D, ser_pkg::REG_FALL}, 1'b1, 1'b0, 32'h0000_0002);
    op({D, ser_pkg::REG_ENABLE}, 1'b1, 1'b0, 32'h0000_0003);
    data_cond_in = 16'h0003;
    repeat (4) @(negedge clk);
    chk(32'(status_byte), 32'h08);
    chk(32'(data_summary), 32'h1);
    rd({D, ser_pkg::REG_COND}, 16'h0003);
    rd({D, ser_pkg::REG_EVENT}, 16'h0001);
    data_cond_in = 16'h0000;
    repeat (4) @(negedge clk);
    rd({D, ser_pkg::REG_EVENT}, 16'h0002);
    rd({D, ser_pkg::REG_EVENT}, 16'h0000);
    repeat (2) @(negedge clk);
    chk(32'(status_byte), 32'h00);
    chk(32'(data_summary), 32'h0);
  endtask
  task automatic t_oper();
    op({O, ser_pkg::REG_ENABLE}, 1'b1, 1'b0, 32'h0000_8000);
    oper_cond_in = 16'h8000;
    repeat (4) @(negedge clk);
    chk(32'(status_byte), 32'h80);
    chk(32'(oper_summary), 32'h1);
    pulse(clear_status_command);
    chk(32'(status_byte), 32'h00);
    chk(32'(oper_summary), 32'h0);
    oper_cond_in = 16'h0000;
    pulse(preset_command);
    t_defaults();
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    t_power_on();
    t_access();
    t_data();
    t_race();
    t_oper();
    stop_test();
  end
  // Tests need about 100 cycles; fifteen times that means a hang
  initial begin
    #15000;
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
